// file: hdl/dls_link3_status.sv
// data link 3 event status register with AXI4-Lite slave and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "dls_defines.svh"
module dls_link3_status
  import dls_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_msg_start,
  input  wire logic        tx_msg_end,
  input  wire logic        rx_msg_start,
  input  wire logic        rx_msg_end,
  input  wire logic        rx_buf_full,
  input  wire logic        rx_chk_fail,
  input  wire logic        rx_msg_done,
  input  wire logic        rx_msg_kind,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_bit_val,
  output logic             irq
);
  dls_events_t   evt_set;
  dls_events_t   evt_q;
  dls_rd_state_t rd_state_r;
  logic [7:0]    mask_r;
  logic          kind_r;
  logic          flag_pulse;
  logic          abort_pulse;
  logic          status_clr;
  logic [7:0]    status_view;
  logic          aw_got_r;
  logic          w_got_r;
  logic [7:0]    awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;

  dls_rx_detect u_detect (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .bit_en      (rx_bit_en),
    .bit_val     (rx_bit_val),
    .flag_pulse  (flag_pulse),
    .abort_pulse (abort_pulse)
  );

  always_comb begin
    evt_set.tx_start   = tx_msg_start;              // see RULE2
    evt_set.rx_start   = rx_msg_start;              // see RULE3
    evt_set.tx_end     = tx_msg_end;                // see RULE4
    evt_set.rx_end     = rx_msg_end | rx_buf_full;  // see RULE8
    evt_set.chk_fail   = rx_chk_fail;               // see RULE11
    evt_set.abort_seen = abort_pulse;               // see RULE9
    evt_set.flag_seen  = flag_pulse;                // see RULE10
  end

  genvar gi;
  generate
    for (gi = 0; gi < $bits(dls_events_t); gi = gi + 1) begin : g_evt
      dls_sticky_bit u_bit (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_i   (evt_set[gi]),
        .clr_i   (status_clr),
        .q       (evt_q[gi])
      );
    end
  endgenerate

  // last received message kind, not cleared by reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_r <= 1'b0;
    end else if (rx_msg_done) begin
      kind_r <= rx_msg_kind; // see RULE1
    end
  end

  assign status_view = {kind_r, evt_q};

  // read channel: one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r    <= DLS_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DLS_RESP_OKAY;
    end else begin
      case (rd_state_r)
        DLS_RD_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            rd_state_r    <= DLS_RD_RESP;
          end
        end
        DLS_RD_RESP: begin
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          s_axi_rresp   <= `DLS_RESP_OKAY;
          if (s_axi_araddr[`DLS_ADDR_MSB:`DLS_ADDR_LSB] ==
              `DLS_ADDR_STATUS >> `DLS_ADDR_LSB) begin
            s_axi_rdata <= {24'h00_0000, status_view};
          end else if (s_axi_araddr[`DLS_ADDR_MSB:`DLS_ADDR_LSB] ==
                       `DLS_ADDR_MASK >> `DLS_ADDR_LSB) begin
            s_axi_rdata <= {24'h00_0000, mask_r};
          end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DLS_RESP_SLVERR;
          end
          rd_state_r <= DLS_RD_HOLD;
        end
        DLS_RD_HOLD: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_r   <= DLS_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= DLS_RD_IDLE;
        end
      endcase
    end
  end

  // araddr held by master until arready edge, sampled at that edge while arready is high
  assign status_clr = (rd_state_r == DLS_RD_RESP) &&
                      (s_axi_araddr[`DLS_ADDR_MSB:`DLS_ADDR_LSB] ==
                       `DLS_ADDR_STATUS >> `DLS_ADDR_LSB); // see RULE5

  // write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_r      <= 8'h00;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        aw_got_r <= 1'b0;
      end else if (s_axi_awvalid && !aw_got_r && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r      <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        w_got_r <= 1'b0;
      end else if (s_axi_wvalid && !w_got_r && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
    end
  end

  // response after both halves; mask is the only writable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DLS_RESP_OKAY;
      mask_r       <= `DLS_MASK_RESET;
    end else if (s_axi_bvalid) begin
      if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end else if (aw_got_r && w_got_r && !s_axi_awready && !s_axi_wready) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r[`DLS_ADDR_MSB:`DLS_ADDR_LSB] == `DLS_ADDR_MASK >> `DLS_ADDR_LSB) begin
        s_axi_bresp <= `DLS_RESP_OKAY;
        if (wstrb_r[0]) begin
          mask_r <= wdata_r[7:0] & `DLS_EVT_MASK;
        end
      end else if (awaddr_r[`DLS_ADDR_MSB:`DLS_ADDR_LSB] == `DLS_ADDR_STATUS >> `DLS_ADDR_LSB) begin
        s_axi_bresp <= `DLS_RESP_OKAY;
      end else begin
        s_axi_bresp <= `DLS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |({1'b0, evt_q} & mask_r & `DLS_EVT_MASK);
    end
  end
endmodule
`default_nettype wire

// file: pkg/dls_defines.svh
// constants for the data link 3 event status block
// Contract
// RULE1: bit 7 reports last received message kind
// RULE2: bit 6 set when transmit message starts
// RULE3: bit 5 set when receive message starts
// RULE4: bit 4 set when transmit message ends
// RULE5: event bits clear when status is read
// RULE6: host refills buffer on transmit start
// RULE7: host loads next buffer before transmit end
// RULE8: bit 3 set on receive end or full
// RULE9: bit 1 set on seven consecutive ones
// RULE10: bit 0 set on flag octet seen
// RULE11: bit 2 set on frame check failure
// RULE12: set event stays set until read
`ifndef DLS_DEFINES_SVH
`define DLS_DEFINES_SVH
`define DLS_ADDR_STATUS     8'h00
`define DLS_ADDR_MASK       8'h04
`define DLS_ADDR_LSB        2
`define DLS_ADDR_MSB        7
`define DLS_BIT_KIND        7
`define DLS_BIT_TX_START    6
`define DLS_BIT_RX_START    5
`define DLS_BIT_TX_END      4
`define DLS_BIT_RX_END      3
`define DLS_BIT_CHK_FAIL    2
`define DLS_BIT_ABORT       1
`define DLS_BIT_FLAG        0
`define DLS_EVT_MASK        8'h7F
`define DLS_MASK_RESET      8'h00
`define DLS_STATUS_RESET    8'h00
`define DLS_RESP_OKAY       2'h0
`define DLS_RESP_SLVERR     2'h2
`define DLS_FLAG_OCTET      8'h7E
`define DLS_ABORT_ONES      3'h7
`endif

// file: pkg/dls_pkg.sv
// types for the data link 3 event status block
package dls_pkg;
  typedef struct packed {
    logic tx_start;
    logic rx_start;
    logic tx_end;
    logic rx_end;
    logic chk_fail;
    logic abort_seen;
    logic flag_seen;
  } dls_events_t;
  typedef enum logic [2:0] {
    DLS_RD_IDLE = 3'b001,
    DLS_RD_RESP = 3'b010,
    DLS_RD_HOLD = 3'b100
  } dls_rd_state_t;
endpackage

// file: hdl/dls_sticky_bit.sv
// one sticky event bit, set wins over read clear
`timescale 1ns/1ps
`default_nettype none
module dls_sticky_bit (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (set_i) begin
      q <= 1'b1; // see RULE12
    end else if (clr_i) begin
      q <= 1'b0; // see RULE5
    end
  end
endmodule
`default_nettype wire

// file: hdl/dls_rx_detect.sv
// serial detector for flag octet and abort ones on the data link
`timescale 1ns/1ps
`default_nettype none
`include "dls_defines.svh"
module dls_rx_detect (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic bit_en,
  input  wire logic bit_val,
  output logic      flag_pulse,
  output logic      abort_pulse
);
  logic [7:0] shift_r;
  logic [2:0] ones_r;
  logic [7:0] shift_nxt;
  assign shift_nxt = {shift_r[6:0], bit_val};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= 8'h00;
    end else if (bit_en) begin
      shift_r <= shift_nxt;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_r <= 3'h0;
    end else if (bit_en) begin
      if (!bit_val) begin
        ones_r <= 3'h0;
      end else if (ones_r != `DLS_ABORT_ONES) begin
        ones_r <= ones_r + 3'h1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_pulse  <= 1'b0;
      abort_pulse <= 1'b0;
    end else begin
      flag_pulse  <= bit_en && (shift_nxt == `DLS_FLAG_OCTET); // see RULE10
      // seventh one in a row, once per run
      abort_pulse <= bit_en && bit_val && (ones_r == (`DLS_ABORT_ONES - 3'h1)); // see RULE9
    end
  end
endmodule
`default_nettype wire

// file: tb/dls_link3_status_assertions.sv
// assertion checker for the data link 3 status block
`timescale 1ns/1ps
`default_nettype none
module dls_link3_status_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_msg_start,
  input wire logic        tx_msg_end,
  input wire logic        rx_msg_start,
  input wire logic        rx_msg_end,
  input wire logic        rx_buf_full,
  input wire logic        rx_chk_fail,
  input wire logic        rx_msg_done,
  input wire logic        rx_msg_kind
);
  logic [6:2] m_r;
  logic       k_r;
  logic       st_r;
  wire logic  clr = s_axi_arready && s_axi_araddr[7:2] == 6'h00;
  // shadow of sticky bits 6 to 2, cleared by a status read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_r  <= 5'h00;
      k_r  <= 1'b0;
      st_r <= 1'b0;
    end else begin
      m_r  <= (clr ? 5'h00 : m_r) | {tx_msg_start, rx_msg_start, tx_msg_end, rx_msg_end | rx_buf_full, rx_chk_fail};
      k_r  <= rx_msg_done ? rx_msg_kind : k_r;
      st_r <= clr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b6; st_r |-> s_axi_rdata[6] == $past(m_r[6]); endproperty
  a_b6: assert property (p_b6) else $error("tx start bit");
  property p_b5; st_r |-> s_axi_rdata[5] == $past(m_r[5]); endproperty
  a_b5: assert property (p_b5) else $error("rx start bit");
  property p_b4; st_r |-> s_axi_rdata[4] == $past(m_r[4]); endproperty
  a_b4: assert property (p_b4) else $error("tx end bit");
  property p_b3; st_r |-> s_axi_rdata[3] == $past(m_r[3]); endproperty
  a_b3: assert property (p_b3) else $error("rx end bit");
  property p_b2; st_r |-> s_axi_rdata[2] == $past(m_r[2]); endproperty
  a_b2: assert property (p_b2) else $error("checksum bit");
  property p_kind; st_r |-> s_axi_rdata[7] == $past(k_r); endproperty
  a_kind: assert property (p_kind) else $error("kind bit");
  property p_lat; s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_lat: assert property (p_lat) else $error("read answer late");
  property p_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data dropped");
  c_tx: cover property (st_r && s_axi_rdata[6]);
  c_kind: cover property (st_r && s_axi_rdata[7]);
  c_chk: cover property (st_r && s_axi_rdata[2]);
endmodule
bind dls_link3_status dls_link3_status_chk chk_u (.*);
`default_nettype wire

// file: tb/dls_host_bfm.sv
// host bus master model reading the status block
`timescale 1ns/1ps
`default_nettype none
module dls_host_bfm (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
  end
  // response 3 marks a wait that ran out
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb/dls_link3_status_tb.sv
// self-checking bench for the data link 3 status block
`timescale 1ns/1ps
`default_nettype none
module dls_link3_status_tb;
  logic aclk, aresetn, rx_msg_done, rx_msg_kind, rx_bit_en, rx_bit_val;
  logic [5:0] ev;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  localparam logic [47:0] exp_bits = {8'h40, 8'h20, 8'h10, 8'h08, 8'h08, 8'h04};
  wire logic tx_msg_start, rx_msg_start, tx_msg_end, rx_msg_end, rx_buf_full, rx_chk_fail, irq;
  wire logic [7:0] s_axi_awaddr, s_axi_araddr;
  wire logic [31:0] s_axi_wdata, s_axi_rdata;
  wire logic [3:0] s_axi_wstrb;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  assign {tx_msg_start, rx_msg_start, tx_msg_end, rx_msg_end, rx_buf_full, rx_chk_fail} = ev;
  dls_link3_status dut_u (.*);
  dls_host_bfm host_u (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task summarize;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    host_u.rd(a, d, r);
    if (r === 2'h3) begin
      num_errors++;
      $display("[ERR] rvalid expected 1 seen 0");
      summarize();
    end else begin
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
    end
  endtask
  task pulse(input logic [5:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 6'h00;
  endtask
  task bits(input logic [7:0] b);
    for (int j = 0; j < 8; j++) begin
      @(posedge aclk);
      {rx_bit_en, rx_bit_val} <= {1'b1, b[j]};
    end
    @(posedge aclk);
    rx_bit_en <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {aresetn, rx_msg_done, rx_msg_kind, rx_bit_en, rx_bit_val, ev} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h00, 32'h0, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    rdc(8'h08, 32'h0, 2'h2);
    host_u.wr(8'h08, 32'h000000FF, r);
    chk("bresp", 32'h2, {30'h0, r});
    host_u.wr(8'h00, 32'h000000FF, r);
    chk("bresp", 32'h0, {30'h0, r});
    for (i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      pulse(6'h01 << i);
      rdc(8'h00, {24'h0, exp_bits[i*8 +: 8]}, 2'h0);
      rdc(8'h00, 32'h0, 2'h0);
    end
    bits(8'h7E);
    rdc(8'h00, 32'h01, 2'h0);
    bits(8'h7F);
    rdc(8'h00, 32'h02, 2'h0);
    for (i = 1; i >= 0; i--) begin
      @(posedge aclk);
      {rx_msg_done, rx_msg_kind} <= {1'b1, i[0]};
      @(posedge aclk);
      rx_msg_done <= 1'b0;
      rdc(8'h00, {24'h0, i[0], 7'h0}, 2'h0);
    end
    host_u.wr(8'h04, 32'hC0, r);
    chk("bresp", 32'h0, {30'h0, r});
    rdc(8'h04, 32'h40, 2'h0);
    pulse(6'h08);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(6'h20);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(8'h00, 32'h50, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    summarize();
  end
endmodule
`default_nettype wire
